// ---- uhp_pkg.sv ----
// constants for the usb host interrupt mask and list pointer registers
package uhp_pkg;
    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned DATA_W            = 32;
    localparam int unsigned EVT_W             = 8;
    // register byte offsets
    localparam logic [7:0] OFF_EVENT_FLAGS    = 8'h0C;
    localparam logic [7:0] OFF_MASK_SET       = 8'h10;
    localparam logic [7:0] OFF_MASK_CLEAR     = 8'h14;
    localparam logic [7:0] OFF_COMM_AREA      = 8'h18;
    localparam logic [7:0] OFF_PERIODIC_DESC  = 8'h1C;
    // field positions
    localparam int unsigned BIT_GLOBAL_IRQ    = 31;
    localparam int unsigned BIT_OWNERSHIP     = 30;
    localparam int unsigned BIT_ROOT_HUB      = 6;
    localparam int unsigned BIT_FRAME_WRAP    = 5;
    localparam int unsigned BIT_FATAL_ERR     = 4;
    localparam int unsigned BIT_RESUME        = 3;
    localparam int unsigned BIT_FRAME_BEGIN   = 2;
    localparam int unsigned BIT_DONE_WB       = 1;
    localparam int unsigned BIT_OVERRUN       = 0;
    localparam int unsigned COMM_LSB          = 8;
    localparam int unsigned DESC_LSB          = 4;
    // implemented bits
    localparam logic [31:0] EVENT_BITS        = 32'h4000_007F;
    localparam logic [31:0] MASK_BITS         = 32'hC000_007F;
    localparam logic [31:0] COMM_AREA_BITS    = 32'hFFFF_FF00;
    localparam logic [31:0] DESC_BITS         = 32'hFFFF_FFF0;
    // reset values
    localparam logic [31:0] MASK_RESET        = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;
endpackage : uhp_pkg

// ---- uhp_w1_bit.sv ----
// one write-one-set / write-one-clear bit with set priority option
`timescale 1ns/100ps
module uhp_w1_bit (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    // controls
    input  wire logic i_set,
    input  wire logic i_clear,
    input  wire logic i_set_wins,
    // state
    output logic      o_value
);
    logic next_value;
    assign next_value = i_set_wins ? (i_set | (o_value & ~i_clear))
                                   : ((o_value | i_set) & ~i_clear);
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_value <= 1'b0;
        end else begin
            o_value <= next_value;
        end
    end
endmodule : uhp_w1_bit

// ---- uhp_bus_read.sv ----
// read data register for the register port
`timescale 1ns/100ps
module uhp_bus_read (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // read select
    input  wire logic        i_read,
    input  wire logic [31:0] i_word,
    // read data
    output logic [31:0]      o_rdata
);
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_read) begin
            o_rdata <= i_word;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule : uhp_bus_read

// ---- uhp_regs.sv ----
// interrupt mask, communication area base and periodic pointer registers
`timescale 1ns/100ps
module uhp_regs (
    // clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_sys_rst,
    // register port
    input  wire logic [uhp_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [uhp_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                   i_write,
    input  wire logic                   i_read,
    output logic [uhp_pkg::DATA_W-1:0]  o_rdata,
    // event sources, one-cycle pulses
    input  wire logic [uhp_pkg::EVT_W-1:0] i_event_pulse,
    // list engine
    input  wire logic                   i_desc_done,
    input  wire logic [31:0]            i_desc_addr,
    output logic [31:0]                 o_comm_area_base,
    output logic [31:0]                 o_periodic_desc_ptr,
    // interrupt
    output logic                        o_irq
);
    import uhp_pkg::*;

    logic [31:0] mask_reg;
    logic [31:0] flag_reg;
    logic [31:0] comm_area_base;
    logic [31:0] periodic_desc_ptr;
    logic [31:0] event_word;
    logic [31:0] read_word;
    logic        wr_set;
    logic        wr_clear;
    logic        wr_flags;
    logic        wr_comm;
    logic        sel_flags;
    logic        sel_set;
    logic        sel_clear;
    logic        sel_comm;
    logic        sel_desc;
    logic        sel_none;
    logic [31:0] pending_word;
    logic        any_pending;

    // address decode
    assign sel_flags = (i_addr == OFF_EVENT_FLAGS);
    assign sel_set   = (i_addr == OFF_MASK_SET);
    assign sel_clear = (i_addr == OFF_MASK_CLEAR);
    assign sel_comm  = (i_addr == OFF_COMM_AREA);
    assign sel_desc  = (i_addr == OFF_PERIODIC_DESC);
    assign sel_none  = !(sel_flags || sel_set || sel_clear || sel_comm || sel_desc);
    assign wr_set    = i_write && sel_set;
    assign wr_clear  = i_write && sel_clear;
    assign wr_flags  = i_write && sel_flags;
    assign wr_comm   = i_write && sel_comm;

    // event pulses placed at their bit positions
    assign event_word = {1'b0, i_event_pulse[7], 23'h00_0000, i_event_pulse[6:0]} & EVENT_BITS;

    // per-bit mask and flag storage
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_bit
            if (MASK_BITS[gi]) begin : g_mask
                uhp_w1_bit u_mask (
                    .i_clock    (i_clock),
                    .i_sys_rst  (i_sys_rst),
                    .i_set      (wr_set & i_wdata[gi]),
                    .i_clear    (wr_clear & i_wdata[gi]),
                    .i_set_wins (1'b0),
                    .o_value    (mask_reg[gi])
                );
            end else begin : g_mask_none
                assign mask_reg[gi] = 1'b0;
            end
            if (EVENT_BITS[gi]) begin : g_flag
                uhp_w1_bit u_flag (
                    .i_clock    (i_clock),
                    .i_sys_rst  (i_sys_rst),
                    .i_set      (event_word[gi]),
                    .i_clear    (wr_flags & i_wdata[gi]),
                    .i_set_wins (1'b1),
                    .o_value    (flag_reg[gi])
                );
            end else begin : g_flag_none
                assign flag_reg[gi] = 1'b0;
            end
        end
    endgenerate

    // base address and periodic pointer
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            comm_area_base <= ZERO_WORD;
        end else if (wr_comm) begin
            comm_area_base <= i_wdata & COMM_AREA_BITS;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            periodic_desc_ptr <= ZERO_WORD;
        end else if (i_desc_done) begin
            periodic_desc_ptr <= i_desc_addr & DESC_BITS;
        end
    end

    assign o_comm_area_base    = comm_area_base;
    assign o_periodic_desc_ptr = periodic_desc_ptr;

    // interrupt request
    assign pending_word = flag_reg & mask_reg & EVENT_BITS;
    assign any_pending  = (pending_word != ZERO_WORD);
    assign o_irq        = mask_reg[BIT_GLOBAL_IRQ] && any_pending;

    // read mux, unmapped reads return zero
    assign read_word = sel_flags ? flag_reg :
                       sel_set   ? mask_reg :
                       sel_clear ? mask_reg :
                       sel_comm  ? comm_area_base :
                       sel_desc  ? periodic_desc_ptr :
                       ZERO_WORD;

    uhp_bus_read u_read (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_read    (i_read),
        .i_word    (read_word),
        .o_rdata   (o_rdata)
    );

    // checks
    mask_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_clear && i_wdata[BIT_OWNERSHIP] |=> !mask_reg[BIT_OWNERSHIP])
        else $error("mask bit not cleared");
    clear_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_clear && !i_wdata[BIT_ROOT_HUB] && !wr_set |=> $stable(mask_reg[BIT_ROOT_HUB]))
        else $error("mask bit changed by zero");
    clear_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_read && i_addr == OFF_MASK_CLEAR |=> o_rdata == $past(mask_reg))
        else $error("clear register read wrong");
    global_off_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_clear && i_wdata[BIT_GLOBAL_IRQ] && !wr_set |=> !o_irq)
        else $error("irq after global disable");
    comm_low_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_read && i_addr == OFF_COMM_AREA |=> o_rdata[7:0] == 8'h00)
        else $error("base low bits not zero");
    comm_write_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_comm |=> comm_area_base == ($past(i_wdata) & COMM_AREA_BITS))
        else $error("base not written");
    desc_update_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_desc_done |=> periodic_desc_ptr == ($past(i_desc_addr) & DESC_BITS))
        else $error("pointer not updated");
    desc_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !i_desc_done |=> $stable(periodic_desc_ptr))
        else $error("pointer changed by software");
    irq_cause_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_irq |-> mask_reg[BIT_GLOBAL_IRQ] && (flag_reg & mask_reg) != ZERO_WORD)
        else $error("irq without cause");
    mask_set_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_set && i_wdata[BIT_FATAL_ERR] && !wr_clear |=> mask_reg[BIT_FATAL_ERR])
        else $error("mask bit not set");

    clear_word_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_clear |=> (mask_reg & $past(i_wdata)) == ZERO_WORD)
        else $error("written ones left mask bits set");

    clear_rest_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_clear |=> (mask_reg & ~$past(i_wdata)) == ($past(mask_reg) & ~$past(i_wdata)))
        else $error("written zeros changed mask bits");

    set_word_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_set |=> (mask_reg & $past(i_wdata)) == ($past(i_wdata) & MASK_BITS))
        else $error("written ones did not set mask bits");

    set_rest_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_set |=> (mask_reg & ~$past(i_wdata)) == ($past(mask_reg) & ~$past(i_wdata)))
        else $error("set write changed other mask bits");

    global_set_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_set && i_wdata[BIT_GLOBAL_IRQ] |=> mask_reg[BIT_GLOBAL_IRQ])
        else $error("global enable not set");

    mask_idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !wr_set && !wr_clear |=> $stable(mask_reg))
        else $error("mask changed without write");

    global_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_clear && i_wdata[BIT_GLOBAL_IRQ] |=> !mask_reg[BIT_GLOBAL_IRQ])
        else $error("global enable not cleared");

    global_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_clear && !i_wdata[BIT_GLOBAL_IRQ] |=>
            mask_reg[BIT_GLOBAL_IRQ] == $past(mask_reg[BIT_GLOBAL_IRQ]))
        else $error("global enable changed by zero");

    rst_clear_a: assert property (@(posedge i_clock)
        $fell(i_sys_rst) |-> mask_reg == ZERO_WORD && flag_reg == ZERO_WORD
            && comm_area_base == ZERO_WORD && periodic_desc_ptr == ZERO_WORD)
        else $error("registers not cleared by reset");

    own_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_event_pulse[7] |=> flag_reg[BIT_OWNERSHIP])
        else $error("ownership flag not set");

    own_win_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_event_pulse[7] && wr_flags && i_wdata[BIT_OWNERSHIP] |=> flag_reg[BIT_OWNERSHIP])
        else $error("ownership event lost to clear");

    own_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_flags && i_wdata[BIT_OWNERSHIP] && !i_event_pulse[7] |=> !flag_reg[BIT_OWNERSHIP])
        else $error("ownership flag not cleared");

    own_irq_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        flag_reg[BIT_OWNERSHIP] && mask_reg[BIT_OWNERSHIP] && mask_reg[BIT_GLOBAL_IRQ] |-> o_irq)
        else $error("ownership event without irq");

    flag_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !wr_flags && i_event_pulse == 8'h00 |=> $stable(flag_reg))
        else $error("flags changed without cause");

    irq_none_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        flag_reg == ZERO_WORD |-> !o_irq)
        else $error("irq with no event");

    set_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_read && sel_set |=> o_rdata == $past(mask_reg))
        else $error("set register read wrong");

    flags_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_read && sel_flags |=> o_rdata == $past(flag_reg))
        else $error("flag register read wrong");

    comm_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_read && sel_comm |=> o_rdata == $past(comm_area_base))
        else $error("base register read wrong");

    desc_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_read && sel_desc |=> o_rdata == $past(periodic_desc_ptr))
        else $error("pointer read wrong");

    none_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_read && sel_none |=> o_rdata == ZERO_WORD)
        else $error("unmapped read not zero");

    read_idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !i_read |=> o_rdata == ZERO_WORD)
        else $error("read data outside read cycle");

    comm_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !wr_comm |=> $stable(comm_area_base))
        else $error("base changed without write");

    comm_zero_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        wr_comm |=> comm_area_base[7:0] == 8'h00)
        else $error("base low bits stored");

    desc_low_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_desc_done |=> periodic_desc_ptr[3:0] == 4'h0)
        else $error("pointer low bits stored");

    desc_ro_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_write && sel_desc && !i_desc_done |=> $stable(periodic_desc_ptr))
        else $error("pointer written by software");

    none_write_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_write && sel_none |=> $stable(mask_reg) && $stable(comm_area_base))
        else $error("unmapped write changed a register");

    genvar gc;
    generate
        for (gc = 0; gc < 7; gc++) begin : g_evt_chk
            evt_set_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
                i_event_pulse[gc] |=> flag_reg[gc])
                else $error("event flag not set");

            evt_win_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
                i_event_pulse[gc] && wr_flags && i_wdata[gc] |=> flag_reg[gc])
                else $error("event lost to clear");

            evt_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
                wr_flags && i_wdata[gc] && !i_event_pulse[gc] |=> !flag_reg[gc])
                else $error("event flag not cleared");

            evt_irq_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
                flag_reg[gc] && mask_reg[gc] && mask_reg[BIT_GLOBAL_IRQ] |-> o_irq)
                else $error("unmasked event without irq");
        end
    endgenerate
endmodule : uhp_regs

// ---- uhp_host_model.sv ----
// register bus master standing in for driver software
`timescale 1ns/100ps
module uhp_host_model (
    // clock
    input  wire logic  i_clock,
    // register port
    output logic [7:0]  o_addr,
    output logic [31:0] o_wdata,
    output logic        o_write,
    output logic        o_read
);
    logic [31:0] exp_q[$];
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_write = 1'b0;
        o_read = 1'b0;
    end
    // one strobe cycle, reads note expected word
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        o_write <= w;
        o_read <= !w;
        o_addr <= a;
        o_wdata <= d;
        if (!w) exp_q.push_back(d);
    endtask : xfer
    // release strobes, scramble data
    task automatic idle();
        @(posedge i_clock);
        o_write <= 1'b0;
        o_read <= 1'b0;
        o_wdata <= ~o_wdata;
    endtask : idle
endmodule : uhp_host_model

// ---- usb_host_irq_mask_and_pointers_tb_top.sv ----
// self-checking bench for mask and pointer registers
`timescale 1ns/100ps
module usb_host_irq_mask_and_pointers_tb_top;
    import uhp_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr, ev;
    logic [31:0] wdata, rdata, base, ptr, dadr, seed, m, d;
    logic        wr, rd, irq, ddone;
    logic        rd_d = 1'b0;
    int          err_count, cmp_count, pos;
    always #2 clock = ~clock;
    uhp_host_model i_host (.i_clock(clock), .o_addr(addr), .o_wdata(wdata),
        .o_write(wr), .o_read(rd));
    uhp_regs i_dut (.i_clock(clock), .i_sys_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_write(wr), .i_read(rd), .o_rdata(rdata),
        .i_event_pulse(ev), .i_desc_done(ddone), .i_desc_addr(dadr),
        .o_comm_area_base(base), .o_periodic_desc_ptr(ptr), .o_irq(irq));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        i_host.xfer(1'b1, a, v);
        i_host.idle();
        #1;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        i_host.xfer(1'b0, a, e);
        i_host.idle();
    endtask : rreg
    // read data compared in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_d) check("rdata", rdata, i_host.exp_q.pop_front());
        rd_d <= rd;
    end
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        summarize();
    end
    initial begin
        seed = 32'h0000_0026;
        ev = 8'h00;
        ddone = 1'b0;
        dadr = 32'h0000_0000;
        m = 32'h0000_0000;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rreg(OFF_MASK_CLEAR, ZERO_WORD);
        rreg(OFF_COMM_AREA, ZERO_WORD);
        for (int k = 0; k < 6; k++) begin
            d = xs();
            wreg(OFF_MASK_SET, d);
            m |= d & MASK_BITS;
            d = xs();
            i_host.xfer(1'b1, OFF_MASK_CLEAR, d);
            m &= ~d;
            rreg(OFF_MASK_CLEAR, m);
            rreg(OFF_MASK_SET, m);
        end
        wreg(OFF_MASK_SET, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++) begin
            pos = (i == 7) ? 30 : i;
            @(posedge clock);
            ev <= 8'h01 << i;
            @(posedge clock);
            ev <= 8'h00;
            #1;
            check("irq", irq, 1'b1);
            wreg(OFF_MASK_CLEAR, 32'h8000_0000);
            check("irq", irq, 1'b0);
            wreg(OFF_MASK_SET, 32'h8000_0000);
            check("irq", irq, 1'b1);
            wreg(OFF_MASK_CLEAR, 32'h0000_0001 << pos);
            check("irq", irq, 1'b0);
            rreg(OFF_EVENT_FLAGS, 32'h0000_0001 << pos);
            wreg(OFF_EVENT_FLAGS, 32'hFFFF_FFFF);
            wreg(OFF_MASK_SET, 32'h0000_0001 << pos);
        end
        i_host.xfer(1'b1, OFF_EVENT_FLAGS, 32'hFFFF_FFFF);
        ev <= 8'h04;
        i_host.xfer(1'b0, OFF_EVENT_FLAGS, 32'h0000_0004);
        ev <= 8'h00;
        i_host.idle();
        wreg(OFF_COMM_AREA, 32'hFFFF_FFFF);
        check("base", base, COMM_AREA_BITS);
        rreg(OFF_COMM_AREA, COMM_AREA_BITS);
        wreg(OFF_PERIODIC_DESC, 32'hFFFF_FFFF);
        check("ptr", ptr, ZERO_WORD);
        d = xs();
        @(posedge clock);
        ddone <= 1'b1;
        dadr <= d;
        @(posedge clock);
        ddone <= 1'b0;
        dadr <= ~d;
        #1;
        check("ptr", ptr, d & DESC_BITS);
        rreg(OFF_PERIODIC_DESC, d & DESC_BITS);
        wreg(8'h40, 32'hFFFF_FFFF);
        rreg(OFF_MASK_CLEAR, MASK_BITS);
        rreg(8'h40, ZERO_WORD);
        repeat (3) @(posedge clock);
        summarize();
    end
endmodule : usb_host_irq_mask_and_pointers_tb_top
